// >>> hw/ccs_keypad.sv
// Keypad frequency setpoint and run command logic
`timescale 1ns/10ps
`include "ccs_cfg.svh"
module ccs_keypad (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ref_active,
  input wire logic i_cmd_active,
  input wire logic i_operate,
  input wire logic i_up,
  input wire logic i_down,
  input wire logic i_forward_key,
  input wire logic i_reverse_key,
  input wire logic i_stop,
  output logic [15:0] o_freq,
  output logic o_run,
  output logic o_rev
);
  ccs_pkg::ccs_kp_state_t kp_q;
  ccs_pkg::ccs_kp_state_t kp_d;
  logic [4:0] keys;
  logic [4:0] press;

  always_comb begin
    keys = {i_stop, i_reverse_key, i_forward_key, i_down, i_up};
    press = keys & ~kp_q.prev;
    kp_d = kp_q;
    kp_d.prev = keys;
    // Keys only act in operate mode while the keypad owns the path [R17]
    if (i_operate && i_ref_active) begin
      if (press[0] && kp_q.freq != `CCS_FREQ_MAX) begin
        kp_d.freq = kp_q.freq + `CCS_FREQ_STEP;
      end else if (press[1] && kp_q.freq != `CCS_RST_FREQ) begin
        kp_d.freq = kp_q.freq - `CCS_FREQ_STEP;
      end
    end
    if (i_operate && i_cmd_active) begin
      // Stop wins over a run key pressed in the same cycle [R17]
      if (press[4]) begin
        kp_d.run = 1'b0;
      end else if (press[2]) begin
        kp_d.run = 1'b1;
        kp_d.reverse_key = 1'b0;
      end else if (press[3]) begin
        kp_d.run = 1'b1;
        kp_d.reverse_key = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      kp_q <= '0;
    end else begin
      kp_q <= kp_d;
    end
  end

  assign o_freq = kp_q.freq;
  assign o_run = kp_q.run;
  assign o_rev = kp_q.reverse_key;
endmodule

// >>> hw/ccs_selector.sv
// Control source selector: routes reference and run commands
// Function
// R1: Route reference and commands independently, three sources
// R2: Keypad-both setting: keypad paths, keypad indicator
// R3: Terminal-both setting: terminal paths, terminal indicator
// R4: Keypad control, terminal reference, matching indicator
// R5: Terminal control, keypad reference, matching indicator
// R6: Fixed settings change only on rewrite
// R7: Input-switched: input false keypad, true terminal
// R8: Function key toggles both paths together
// R9: Serial-switched: bit 11 picks keypad or terminal
// R10: Switched modes never give mixed assignment
// R11: Control word bit 0 gives commands to serial
// R12: Control word bit 1 gives reference to serial
// R13: Exactly one serial bit: partial indicator
// R14: Both serial bits: complete indicator
// R15: Override input ignores serial bits 0 and 1
// R16: Read-only status of both active sources
// R17: Keypad keys adjust frequency and run commands
// R18: Terminal inputs make reference and run commands
// R19: Serial master supplies reference and run commands
// R20: Override only effective with a serial bit set
// R21: Bit 4 picks external reference 1 or 2
// R22: Selections and indicator registered every clock
// R23: Reset clears control word, selects keypad
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ccs_cfg.svh"
module ccs_selector (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_kp_up,
  input wire logic i_kp_down,
  input wire logic i_forward_key,
  input wire logic i_reverse_key,
  input wire logic i_kp_stop,
  input wire logic i_kp_operate,
  input wire logic i_kp_fkey,
  input wire logic i_di_switch,
  input wire logic i_di_override,
  input wire logic i_di_preset,
  input wire logic i_term_fwd,
  input wire logic i_term_rev,
  input wire logic [15:0] i_term_ain,
  output logic [1:0] o_ref_src,
  output logic [1:0] o_cmd_src,
  output logic [2:0] o_indicator,
  output logic [15:0] o_freq_ref,
  output logic o_run,
  output logic o_reverse
);
  ccs_pkg::ccs_state_t q;
  ccs_pkg::ccs_state_t d;
  logic [11:0] pins_s;
  logic up_s, down_s, fwd_s, rev_s, stop_s, oper_s, fkey_s;
  logic sw_s, ovr_s, pre_s, tfwd_s, trev_s;
  logic [15:0] kp_freq;
  logic kp_run, kp_rev;
  logic sw_term, ovr_act, ser_cmd, ser_ref;
  ccs_pkg::ccs_src_t base_ref, base_cmd;
  logic [2:0] base_ind;
  logic setup, access, wr_ok;
  logic [31:0] status;

  // Every pin is asynchronous to the control clock
  ccs_sync #(.W(12)) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_kp_up, i_kp_down, i_forward_key, i_reverse_key, i_kp_stop,
              i_kp_operate, i_kp_fkey, i_di_switch, i_di_override,
              i_di_preset, i_term_fwd, i_term_rev}),
    .o_sync(pins_s)
  );

  assign {up_s, down_s, fwd_s, rev_s, stop_s, oper_s, fkey_s,
          sw_s, ovr_s, pre_s, tfwd_s, trev_s} = pins_s;

  ccs_keypad u_keypad (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ref_active(q.ref_src == ccs_pkg::CCS_SRC_KEYPAD),
    .i_cmd_active(q.cmd_src == ccs_pkg::CCS_SRC_KEYPAD),
    .i_operate(oper_s),
    .i_up(up_s),
    .i_down(down_s),
    .i_forward_key(fwd_s),
    .i_reverse_key(rev_s),
    .i_stop(stop_s),
    .o_freq(kp_freq),
    .o_run(kp_run),
    .o_rev(kp_rev)
  );

  always_comb begin
    d = q;
    sw_term = 1'b0;
    base_ref = ccs_pkg::CCS_SRC_KEYPAD;
    base_cmd = ccs_pkg::CCS_SRC_KEYPAD;
    base_ind = `CCS_IND_KP_BOTH;
    // Toggle tracked in every mode so the key state is current on entry
    d.fkey_prev = fkey_s;
    if (fkey_s && !q.fkey_prev) begin
      d.fkey_term = !q.fkey_term; // [R8]
    end
    // Fixed settings depend on the stored selector alone [R6]
    case (q.mode)
      `CCS_MODE_TERM_BOTH: begin
        base_ref = ccs_pkg::CCS_SRC_TERMINAL; // [R3]
        base_cmd = ccs_pkg::CCS_SRC_TERMINAL;
        base_ind = `CCS_IND_TERM_BOTH;
      end
      `CCS_MODE_KCTL_TREF: begin
        base_ref = ccs_pkg::CCS_SRC_TERMINAL; // [R4]
        base_ind = `CCS_IND_KCTL_TREF;
      end
      `CCS_MODE_TCTL_KREF: begin
        base_cmd = ccs_pkg::CCS_SRC_TERMINAL; // [R5]
        base_ind = `CCS_IND_TCTL_KREF;
      end
      `CCS_MODE_INPUT_SW, `CCS_MODE_FKEY_SW, `CCS_MODE_SERIAL_SW: begin
        if (q.mode == `CCS_MODE_INPUT_SW) begin
          sw_term = sw_s; // [R7]
        end else if (q.mode == `CCS_MODE_FKEY_SW) begin
          sw_term = q.fkey_term; // [R8]
        end else begin
          sw_term = q.ctlw[`CCS_CW_TK]; // [R9]
        end
        // One switch drives both paths, so no mixed pair can occur [R10]
        if (sw_term) begin
          base_ref = ccs_pkg::CCS_SRC_TERMINAL;
          base_cmd = ccs_pkg::CCS_SRC_TERMINAL;
          base_ind = `CCS_IND_TERM_BOTH;
        end
      end
      default: begin
        base_ind = `CCS_IND_KP_BOTH; // [R2]
      end
    endcase
    ovr_act = ovr_s && (q.ctlw[`CCS_CW_CMD] || q.ctlw[`CCS_CW_REF]); // [R20]
    ser_cmd = q.ctlw[`CCS_CW_CMD] && !ovr_act; // [R11] [R15]
    ser_ref = q.ctlw[`CCS_CW_REF] && !ovr_act; // [R12] [R15]
    // Both paths chosen separately and registered each cycle [R1] [R22]
    d.cmd_src = ser_cmd ? ccs_pkg::CCS_SRC_SERIAL : base_cmd;
    d.ref_src = ser_ref ? ccs_pkg::CCS_SRC_SERIAL : base_ref;
    if (ser_cmd && ser_ref) begin
      d.ind = `CCS_IND_SER_CPL; // [R14]
    end else if (ser_cmd || ser_ref) begin
      d.ind = `CCS_IND_SER_PART; // [R13]
    end else begin
      d.ind = base_ind;
    end
    case (d.ref_src)
      ccs_pkg::CCS_SRC_TERMINAL: begin
        d.freq = pre_s ? q.preset : i_term_ain; // [R18]
      end
      ccs_pkg::CCS_SRC_SERIAL: begin
        d.freq = q.ctlw[`CCS_CW_REFSEL] ? q.ext2 : q.ext1; // [R21] [R19]
      end
      default: begin
        d.freq = kp_freq; // [R17]
      end
    endcase
    case (d.cmd_src)
      ccs_pkg::CCS_SRC_TERMINAL: begin
        // Both inputs together read as stop, a safe tie-break
        d.run = tfwd_s ^ trev_s; // [R18]
        d.reverse_key = trev_s && !tfwd_s;
      end
      ccs_pkg::CCS_SRC_SERIAL: begin
        d.run = q.ctlw[`CCS_CW_RUN]; // [R19]
        d.reverse_key = q.ctlw[`CCS_CW_REV];
      end
      default: begin
        d.run = kp_run; // [R17]
        d.reverse_key = kp_rev;
      end
    endcase
    // APB slave: answer prepared in setup, pready high in access only
    setup = i_psel && !i_penable;
    access = i_psel && i_penable && q.pready;
    wr_ok = access && i_pwrite && !q.pslverr;
    status = {{`CCS_ST_PAD{1'b0}}, ovr_act, q.ind,
              q.cmd_src, q.ref_src};
    d.pready = setup;
    d.pslverr = 1'b0;
    d.prdata = `CCS_RST_WORD;
    if (setup) begin
      case (i_paddr)
        `CCS_ADDR_CFG: d.prdata = {29'h0000_0000, q.mode};
        `CCS_ADDR_CTLW: d.prdata = q.ctlw;
        `CCS_ADDR_EXT1: d.prdata = {16'h0000, q.ext1};
        `CCS_ADDR_EXT2: d.prdata = {16'h0000, q.ext2};
        `CCS_ADDR_STATUS: d.prdata = status; // [R16]
        `CCS_ADDR_PRESET: d.prdata = {16'h0000, q.preset};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (wr_ok) begin
      case (i_paddr)
        `CCS_ADDR_CFG: d.mode = i_pwdata[2:0]; // [R6]
        `CCS_ADDR_CTLW: d.ctlw = i_pwdata;
        `CCS_ADDR_EXT1: d.ext1 = i_pwdata[15:0];
        `CCS_ADDR_EXT2: d.ext2 = i_pwdata[15:0];
        `CCS_ADDR_PRESET: d.preset = i_pwdata[15:0];
        default: d.preset = q.preset;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Keypad owns both paths until software loads a setting [R23]
      q <= '0;
      q.mode <= `CCS_RST_MODE;
      q.ctlw <= `CCS_RST_WORD;
      q.ref_src <= ccs_pkg::CCS_SRC_KEYPAD;
      q.cmd_src <= ccs_pkg::CCS_SRC_KEYPAD;
      q.ind <= `CCS_IND_KP_BOTH;
    end else begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_ref_src = q.ref_src;
  assign o_cmd_src = q.cmd_src;
  assign o_indicator = q.ind;
  assign o_freq_ref = q.freq;
  assign o_run = q.run;
  assign o_reverse = q.reverse_key;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_serial_cmd_path: assert property ( // [R11]
    q.ctlw[`CCS_CW_CMD] && !ovr_s |=> o_cmd_src == ccs_pkg::CCS_SRC_SERIAL)
    else $error("serial command path not taken");
  a_serial_ref_path: assert property ( // [R12]
    q.ctlw[`CCS_CW_REF] && !ovr_s |=> o_ref_src == ccs_pkg::CCS_SRC_SERIAL)
    else $error("serial reference path not taken");
  a_partial_ind: assert property ( // [R13]
    !ovr_s && (q.ctlw[`CCS_CW_CMD] != q.ctlw[`CCS_CW_REF])
    |=> o_indicator == `CCS_IND_SER_PART)
    else $error("partial indicator missing");
  a_complete_ind: assert property ( // [R14]
    !ovr_s && q.ctlw[`CCS_CW_CMD] && q.ctlw[`CCS_CW_REF]
    |=> o_indicator == `CCS_IND_SER_CPL)
    else $error("complete indicator missing");
  a_override_blocks: assert property ( // [R15]
    ovr_s |=> o_cmd_src != ccs_pkg::CCS_SRC_SERIAL
    && o_ref_src != ccs_pkg::CCS_SRC_SERIAL)
    else $error("override did not block serial path");
  a_switch_no_mix: assert property ( // [R10]
    (q.mode == `CCS_MODE_INPUT_SW || q.mode == `CCS_MODE_FKEY_SW
    || q.mode == `CCS_MODE_SERIAL_SW) && !q.ctlw[`CCS_CW_CMD]
    && !q.ctlw[`CCS_CW_REF] |=> o_ref_src == o_cmd_src)
    else $error("mixed assignment in switched mode");
  a_input_switch: assert property ( // [R7]
    q.mode == `CCS_MODE_INPUT_SW && q.ctlw[1:0] == 2'h0
    |=> o_ref_src == ($past(sw_s) ? ccs_pkg::CCS_SRC_TERMINAL
    : ccs_pkg::CCS_SRC_KEYPAD))
    else $error("input switch path wrong");
  a_serial_switch: assert property ( // [R9]
    q.mode == `CCS_MODE_SERIAL_SW && q.ctlw[`CCS_CW_TK]
    && q.ctlw[1:0] == 2'h0 |=> o_cmd_src == ccs_pkg::CCS_SRC_TERMINAL)
    else $error("serial switch bit ignored");
  a_mixed_kctl: assert property ( // [R4]
    q.mode == `CCS_MODE_KCTL_TREF && q.ctlw[1:0] == 2'h0
    |=> o_cmd_src == ccs_pkg::CCS_SRC_KEYPAD
    && o_ref_src == ccs_pkg::CCS_SRC_TERMINAL
    && o_indicator == `CCS_IND_KCTL_TREF)
    else $error("keypad control setting wrong");
  a_ext_ref_sel: assert property ( // [R21]
    q.ctlw[`CCS_CW_REF] && !ovr_s && q.ctlw[`CCS_CW_REFSEL]
    |=> o_freq_ref == $past(q.ext2))
    else $error("external reference 2 not used");

  // Fixed settings and switched modes with the serial bits clear
  a_keypad_both: assert property ( // [R2]
    q.mode == `CCS_MODE_KP_BOTH && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    |=> o_ref_src == ccs_pkg::CCS_SRC_KEYPAD && o_cmd_src == ccs_pkg::CCS_SRC_KEYPAD
    && o_indicator == `CCS_IND_KP_BOTH)
    else $error("keypad both setting wrong");

  a_terminal_both: assert property ( // [R3]
    q.mode == `CCS_MODE_TERM_BOTH && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    |=> o_ref_src == ccs_pkg::CCS_SRC_TERMINAL && o_cmd_src == ccs_pkg::CCS_SRC_TERMINAL
    && o_indicator == `CCS_IND_TERM_BOTH)
    else $error("terminal both setting wrong");

  a_mixed_tctl: assert property ( // [R5]
    q.mode == `CCS_MODE_TCTL_KREF && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    |=> o_cmd_src == ccs_pkg::CCS_SRC_TERMINAL && o_ref_src == ccs_pkg::CCS_SRC_KEYPAD
    && o_indicator == `CCS_IND_TCTL_KREF)
    else $error("terminal control setting wrong");

  a_fkey_switch: assert property ( // [R8]
    q.mode == `CCS_MODE_FKEY_SW && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    |=> o_ref_src == ($past(q.fkey_term) ? ccs_pkg::CCS_SRC_TERMINAL
    : ccs_pkg::CCS_SRC_KEYPAD))
    else $error("function key switch path wrong");

  a_fixed_hold: assert property ( // [R6]
    q.mode < `CCS_MODE_INPUT_SW && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    && $stable(q.mode) && $stable(q.ctlw)
    |=> $stable(o_ref_src) && $stable(o_cmd_src)
    && $stable(o_indicator))
    else $error("fixed setting moved without rewrite");

  // A pin change other than a keypad input reaches the outputs one cycle after it is synchronised
  a_switch_next: assert property ( // [R22]
    q.mode == `CCS_MODE_INPUT_SW && $stable(q.mode) && $stable(q.ctlw)
    && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF] && $changed(sw_s)
    |=> $changed(o_ref_src))
    else $error("switch input not registered next cycle");

  a_keypad_freq: assert property ( // [R17]
    q.mode == `CCS_MODE_KP_BOTH && !q.ctlw[`CCS_CW_CMD] && !q.ctlw[`CCS_CW_REF]
    |=> o_freq_ref == $past(kp_freq))
    else $error("keypad reference not used");

  a_term_stop: assert property ( // [R18]
    tfwd_s && trev_s
    |=> !(o_cmd_src == ccs_pkg::CCS_SRC_TERMINAL && o_run))
    else $error("terminal both directions did not stop");

  a_serial_run: assert property ( // [R19]
    q.ctlw[`CCS_CW_CMD] && !ovr_s
    |=> o_run == $past(q.ctlw[`CCS_CW_RUN])
    && o_reverse == $past(q.ctlw[`CCS_CW_REV]))
    else $error("serial run command not followed");

  // Reset leaves the keypad in charge of both paths
  a_reset_keypad: assert property ( // [R23]
    $fell(i_sys_rst) |-> o_ref_src == ccs_pkg::CCS_SRC_KEYPAD
    && o_cmd_src == ccs_pkg::CCS_SRC_KEYPAD && o_indicator == `CCS_IND_KP_BOTH
    && !o_run && q.ctlw == `CCS_RST_WORD)
    else $error("reset did not select keypad");

  c_serial_cpl: cover property (o_indicator == `CCS_IND_SER_CPL);
  c_override: cover property (ovr_act ##1 o_cmd_src == ccs_pkg::CCS_SRC_TERMINAL);
  c_fkey_flip: cover property (q.mode == `CCS_MODE_FKEY_SW && $rose(q.fkey_term));
  c_apb_write: cover property (wr_ok && i_paddr == `CCS_ADDR_CFG);
  c_term_preset: cover property (pre_s && o_ref_src == ccs_pkg::CCS_SRC_TERMINAL);
endmodule

// >>> hw/ccs_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module ccs_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ccs_sync_st_t;

  ccs_sync_st_t sync_q;
  ccs_sync_st_t sync_d;

  always_comb begin
    sync_d.s1 = i_async;
    sync_d.s2 = sync_q.s1;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q.s2;
endmodule

// >>> inc/ccs_cfg.svh
// Constants for the control source selector
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_ADDR_CFG 8'h00
`define CCS_ADDR_CTLW 8'h04
`define CCS_ADDR_EXT1 8'h08
`define CCS_ADDR_EXT2 8'h0C
`define CCS_ADDR_STATUS 8'h10
`define CCS_ADDR_PRESET 8'h14
`define CCS_MODE_KP_BOTH 3'h0
`define CCS_MODE_TERM_BOTH 3'h1
`define CCS_MODE_KCTL_TREF 3'h2
`define CCS_MODE_TCTL_KREF 3'h3
`define CCS_MODE_INPUT_SW 3'h4
`define CCS_MODE_FKEY_SW 3'h5
`define CCS_MODE_SERIAL_SW 3'h6
`define CCS_IND_KP_BOTH 3'h0
`define CCS_IND_TERM_BOTH 3'h1
`define CCS_IND_KCTL_TREF 3'h2
`define CCS_IND_TCTL_KREF 3'h3
`define CCS_IND_SER_PART 3'h4
`define CCS_IND_SER_CPL 3'h5
`define CCS_CW_CMD 0
`define CCS_CW_REF 1
`define CCS_CW_RUN 2
`define CCS_CW_REV 3
`define CCS_CW_REFSEL 4
`define CCS_CW_TK 11
`define CCS_ST_PAD 24
`define CCS_RST_MODE 3'h0
`define CCS_RST_WORD 32'h0000_0000
`define CCS_RST_FREQ 16'h0000
`define CCS_FREQ_STEP 16'h0001
`define CCS_FREQ_MAX 16'hFFFF
`endif

// >>> inc/ccs_pkg.sv
// Types shared by the control source selector
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_SRC_KEYPAD,
    CCS_SRC_TERMINAL,
    CCS_SRC_SERIAL
  } ccs_src_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [31:0] ctlw;
    logic [15:0] ext1;
    logic [15:0] ext2;
    logic [15:0] preset;
    logic fkey_term;
    logic fkey_prev;
    ccs_src_t ref_src;
    ccs_src_t cmd_src;
    logic [2:0] ind;
    logic [15:0] freq;
    logic run;
    logic reverse_key;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccs_state_t;

  typedef struct packed {
    logic [4:0] prev;
    logic [15:0] freq;
    logic run;
    logic reverse_key;
  } ccs_kp_state_t;
endpackage

// >>> verif/ccs_far_model.sv
// Far-side model: serial link master on APB, keypad keys and terminal strip
`timescale 1ns/10ps
module ccs_far_model (
  input wire logic i_mclk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [11:0] o_pins,
  output logic [15:0] o_ain
);
  initial begin
    o_psel = 1'h0;
    o_penable = 1'h0;
    o_pwrite = 1'h0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_pins = 12'h000;
    o_ain = 16'h0000;
  end
  // Link master: run and reference words reach the drive only this way
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge i_mclk);
    o_psel <= 1'h1;
    o_penable <= 1'h0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= wd;
    @(posedge i_mclk);
    o_penable <= 1'h1;
    do @(posedge i_mclk); while (i_pready !== 1'h1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'h0;
    o_penable <= 1'h0;
    // Released lines must not keep the last value
    o_paddr <= ~a;
    o_pwdata <= ~wd;
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge i_mclk);
    o_pins[i] <= v;
  endtask
  task automatic set_ain(input logic [15:0] v);
    @(posedge i_mclk);
    o_ain <= v;
  endtask
  // Keys are held past the synchroniser so every press is seen once
  task automatic press(input int i);
    pin(i, 1'h1);
    repeat (6) @(posedge i_mclk);
    pin(i, 1'h0);
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the control source selector
`timescale 1ns/10ps
`include "ccs_cfg.svh"
module testbench;
  localparam int UP = 0, DN = 1, FK = 2, RK = 3, ST = 4, OP = 5;
  localparam int FN = 6, SW = 7, OV = 8, PR = 9, TF = 10, TR = 11;
  localparam logic [1:0] KP = 2'h0, TM = 2'h1, SR = 2'h2;
  logic mclk, rst, psel, pen, pwr, pready, perr, run, reverse_key, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] pins;
  logic [15:0] ain, freq;
  logic [1:0] rsrc, csrc;
  logic [2:0] ind;
  logic fk = 1'h0;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  ccs_far_model far_u (.i_mclk(mclk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(perr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_pins(pins), .o_ain(ain));
  ccs_selector dut_u (.i_mclk(mclk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_kp_up(pins[UP]), .i_kp_down(pins[DN]),
    .i_forward_key(pins[FK]), .i_reverse_key(pins[RK]), .i_kp_stop(pins[ST]),
    .i_kp_operate(pins[OP]), .i_kp_fkey(pins[FN]), .i_di_switch(pins[SW]),
    .i_di_override(pins[OV]), .i_di_preset(pins[PR]), .i_term_fwd(pins[TF]),
    .i_term_rev(pins[TR]), .i_term_ain(ain), .o_ref_src(rsrc), .o_cmd_src(csrc),
    .o_indicator(ind), .o_freq_ref(freq), .o_run(run), .o_reverse(reverse_key));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Run is a few hundred cycles; the ceiling only catches a hung handshake
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait6;
    repeat (6) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    far_u.xfer(1'h1, a, d, rd, err);
  endtask
  task automatic rdr(input logic [7:0] a);
    far_u.xfer(1'h0, a, 32'h0, rd, err);
  endtask
  task automatic sel(input logic [1:0] r, input logic [1:0] c, input logic [2:0] i);
    wait6();
    chk({rsrc, csrc, ind}, {r, c, i});
  endtask
  task automatic t_reset;
    @(posedge mclk);
    chk({rsrc, csrc, ind, freq, run, reverse_key}, 32'h0);
    rdr(`CCS_ADDR_CTLW);
    chk(rd, 32'h0);
  endtask
  task automatic t_keypad;
    far_u.pin(OP, 1'h1);
    repeat (3) far_u.press(UP);
    far_u.press(DN);
    chk(freq, 16'h0002);
    far_u.press(FK);
    chk({run, reverse_key}, 2'h2);
    far_u.press(RK);
    chk({run, reverse_key}, 2'h3);
    far_u.press(ST);
    chk(run, 1'h0);
    far_u.pin(OP, 1'h0);
    far_u.press(UP);
    chk(freq, 16'h0002);
  endtask
  task automatic t_fixed;
    logic [1:0] r, c;
    for (int m = 0; m < 4; m++) begin
      r = (m == 1 || m == 2) ? TM : KP;
      c = (m == 1 || m == 3) ? TM : KP;
      far_u.set_ain(16'h0100 + m[15:0]);
      wr(`CCS_ADDR_CFG, 32'(m));
      sel(r, c, m[2:0]);
      chk(freq, (r == TM) ? 16'h0100 + m[15:0] : 16'h0002);
      far_u.pin(SW, 1'h1);
      far_u.press(FN);
      fk = ~fk;
      sel(r, c, m[2:0]);
      far_u.pin(SW, 1'h0);
    end
  endtask
  task automatic t_switched;
    wr(`CCS_ADDR_CFG, 32'h4);
    sel(KP, KP, 3'h0);
    far_u.pin(SW, 1'h1);
    sel(TM, TM, 3'h1);
    far_u.pin(SW, 1'h0);
    wr(`CCS_ADDR_CFG, 32'h5);
    sel({1'h0, fk}, {1'h0, fk}, {2'h0, fk});
    far_u.press(FN);
    fk = ~fk;
    sel({1'h0, fk}, {1'h0, fk}, {2'h0, fk});
    wr(`CCS_ADDR_CFG, 32'h6);
    sel(KP, KP, 3'h0);
    wr(`CCS_ADDR_CTLW, 32'h800);
    sel(TM, TM, 3'h1);
  endtask
  task automatic t_serial;
    wr(`CCS_ADDR_CFG, 32'h0);
    wr(`CCS_ADDR_EXT1, 32'h1111);
    wr(`CCS_ADDR_EXT2, 32'h2222);
    wr(`CCS_ADDR_CTLW, 32'h1);
    sel(KP, SR, 3'h4);
    wr(`CCS_ADDR_CTLW, 32'h2);
    sel(SR, KP, 3'h4);
    chk(freq, 16'h1111);
    wr(`CCS_ADDR_CTLW, 32'h1F);
    sel(SR, SR, 3'h5);
    chk({freq, run, reverse_key}, {16'h2222, 2'h3});
    wr(`CCS_ADDR_CTLW, 32'h7);
    wait6();
    chk({freq, run, reverse_key}, {16'h1111, 2'h2});
  endtask
  task automatic t_override;
    wr(`CCS_ADDR_CFG, 32'h1);
    wr(`CCS_ADDR_CTLW, 32'h3);
    far_u.pin(OV, 1'h1);
    sel(TM, TM, 3'h1);
    rdr(`CCS_ADDR_STATUS);
    chk(rd, 32'h95);
    wr(`CCS_ADDR_CTLW, 32'h0);
    wait6();
    rdr(`CCS_ADDR_STATUS);
    chk(rd, 32'h15);
    far_u.pin(OV, 1'h0);
    wr(`CCS_ADDR_CTLW, 32'h3);
    sel(SR, SR, 3'h5);
    rdr(`CCS_ADDR_STATUS);
    chk(rd, 32'h5A);
  endtask
  task automatic t_terminal;
    wr(`CCS_ADDR_CTLW, 32'h0);
    far_u.set_ain(16'h1234);
    far_u.pin(TF, 1'h1);
    wait6();
    chk({freq, run, reverse_key}, {16'h1234, 2'h2});
    far_u.pin(TR, 1'h1);
    wait6();
    chk(run, 1'h0);
    far_u.pin(TF, 1'h0);
    wait6();
    chk({run, reverse_key}, 2'h3);
    wr(`CCS_ADDR_PRESET, 32'hABCD);
    far_u.pin(PR, 1'h1);
    wait6();
    chk(freq, 16'hABCD);
  endtask
  task automatic t_regs;
    wr(`CCS_ADDR_STATUS, 32'hFFFF_FFFF);
    chk(err, 1'h0);
    rdr(`CCS_ADDR_STATUS);
    chk(rd, 32'h15);
    wr(8'h20, 32'h5);
    chk(err, 1'h1);
    rdr(8'h20);
    chk({err, rd}, {1'h1, 32'h0});
    rdr(`CCS_ADDR_CFG);
    chk(rd, 32'h1);
    rdr(`CCS_ADDR_EXT1);
    chk(rd, 32'h1111);
  endtask
  task automatic t_midreset;
    wr(`CCS_ADDR_CFG, 32'h7);
    sel(KP, KP, 3'h0);
    wr(`CCS_ADDR_CTLW, 32'h1F);
    sel(SR, SR, 3'h5);
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
  endtask
  initial begin
    rst = 1'h1;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_keypad();
    t_fixed();
    t_switched();
    t_serial();
    t_override();
    t_terminal();
    t_regs();
    t_midreset();
    test_done();
  end
endmodule
